/* File: verilog/sbc_regs.svh */
// register offsets, field positions, reset values and timing figures of the smbus controller
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH
`define SBC_OFF_CTL_MAIN 8'h00
`define SBC_OFF_CTL_DMA 8'h04
`define SBC_OFF_OWN_ADDR 8'h08
`define SBC_OFF_STATUS 8'h20
`define SBC_OFF_PEC 8'h24
`define SBC_RST_CTL_MAIN 16'h0000
`define SBC_RST_CTL_DMA 16'h0000
`define SBC_RST_OWN_ADDR 16'h0000
`define SBC_MASK_CTL_MAIN 16'hbffb
`define SBC_MASK_CTL_DMA 16'h1f3f
`define SBC_MASK_OWN_ADDR 16'h83ff
`define SBC_MASK_STATUS 16'hdfdf
`define SBC_MASK_ERR 16'hdf00
`define SBC_B_SOFT_RESET_HOLD 15
`define SBC_B_ALERT 13
`define SBC_B_PECREQ 12
`define SBC_B_POS 11
`define SBC_B_ACK 10
`define SBC_B_STOP 9
`define SBC_B_START 8
`define SBC_B_NOSTRETCH 7
`define SBC_B_GCALL 6
`define SBC_B_PECON 5
`define SBC_B_ARP 4
`define SBC_B_HOST 3
`define SBC_B_SMB 1
`define SBC_B_EN 0
`define SBC_B_DMALAST 12
`define SBC_B_DMA_REQUEST_ON 11
`define SBC_B_BUFFER_IRQ_ON 10
`define SBC_B_EVENT_IRQ_ON 9
`define SBC_B_ERROR_IRQ_ON 8
`define SBC_B_TENBIT 15
`define SBC_S_ALERT 15
`define SBC_S_TMO 14
`define SBC_S_PEC 12
`define SBC_S_OVR 11
`define SBC_S_ACK 10
`define SBC_S_ARB 9
`define SBC_S_BUS_ERROR_FLAG 8
`define SBC_CLK_KHZ 40000
`define SBC_TMO_MS 25
`define SBC_FAULT_MS 35
`define SBC_MIN_SCL_KHZ 10
`define SBC_CRC_INIT 8'h00
`define SBC_CRC_POLY 8'h07
`endif

/* File: verilog/sbc_pkg.sv */
// types and the crc step shared by the smbus controller
package sbc_pkg;
    typedef logic [15:0] sbc_reg_t;
    typedef logic [7:0] sbc_byte_t;

    // one crc-8 step over a whole byte, msb first, poly x^8+x^2+x+1
    function automatic sbc_byte_t sbc_crc8(input sbc_byte_t crc, input sbc_byte_t data,
                                           input sbc_byte_t poly);
        sbc_byte_t c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ poly) : (c << 1);
        end
        return c;
    endfunction
endpackage

/* File: verilog/sbc_ctrl.sv */
// control, configuration, timeout, pec and interrupt gating of the smbus controller
//
// Functional notes
// - scl low over 35 ms flags bus fault
// - scl half period clamped to 10 kHz floor, smbus mode only
// - pec is crc-8 0x07, zero seed, all bytes
// - control bit 15 holds controller in reset
// - bit 13 drives alert pin low
// - pec request cleared on pec, start, stop, disable
// - bit 11 picks current or next byte
// - bit 10 ack enable, cleared when disabled
// - stop request set on timeout, cleared on stop
// - start request cleared on start or disable
// - bit 7 disables slave clock stretching
// - bit 6 answers general call address 0x00
// - pec, arp, host type, smbus, enable bits
// - dma enable bit 11, last transfer bit 12
// - event enable gates event flags to interrupt
// - buffer flags interrupt only with event enable
// - error enable gates error flags to interrupt
// - timeout flag after scl low 25 ms
// - error flags stick until written zero
`timescale 1ns/1ps
`include "sbc_regs.svh"

module sbc_ctrl
    import sbc_pkg::*;
#(
    parameter int TMO_CYC = `SBC_TMO_MS * `SBC_CLK_KHZ,
    parameter int FAULT_CYC = `SBC_FAULT_MS * `SBC_CLK_KHZ
) (
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // bus pins
    input wire logic scl_in,
    input wire logic alert_pin_in,
    output logic alert_pin_out,
    output logic alert_pin_oe_n,
    // byte engine events, one-cycle pulses
    input wire logic start_seen,
    input wire logic stop_seen,
    input wire logic pec_done,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic addr_valid,
    input wire logic bus_error_evt,
    input wire logic arb_lost_evt,
    input wire logic ack_error_evt,
    input wire logic overrun_evt,
    input wire logic crc_mismatch_evt,
    // byte engine status levels
    input wire logic start_sent_flag,
    input wire logic address_flag,
    input wire logic header_sent_flag,
    input wire logic stop_seen_flag,
    input wire logic byte_done_flag,
    input wire logic tx_empty_flag,
    input wire logic rx_full_flag,
    input wire logic host_header_seen,
    input wire logic default_addr_seen,
    input wire logic [15:0] scl_half_req,
    // controls to the byte engine
    output logic engine_reset,
    output logic controller_on,
    output logic smbus_mode_select,
    output logic smbus_host_type,
    output logic addr_resolution_on,
    output logic pec_calc_on,
    output logic general_call_respond,
    output logic stretch_off,
    output logic gen_start,
    output logic gen_stop,
    output logic acknowledge_on,
    output logic ack_position_next,
    output logic pec_byte_request,
    output logic dma_request_on,
    output logic dma_final_transfer,
    output logic [5:0] periph_clock_mhz,
    output logic [15:0] scl_half_cycles,
    output logic [7:0] pec_value,
    output logic addr_match,
    output logic general_call_hit,
    output logic scl_stuck_fault,
    output logic event_irq,
    output logic error_irq
);
    localparam logic [15:0] HALF_MAX = 16'(`SBC_CLK_KHZ / (2 * `SBC_MIN_SCL_KHZ));
    localparam int CW = $clog2(FAULT_CYC + 1);
    localparam logic [CW-1:0] TMO_C = CW'(TMO_CYC);
    localparam logic [CW-1:0] FAULT_C = CW'(FAULT_CYC);

    sbc_reg_t ctl_main_r, ctl_main_nxt;
    sbc_reg_t ctl_dma_r;
    sbc_reg_t own_addr_r;
    sbc_reg_t err_r, err_nxt;
    sbc_byte_t crc_r;
    logic [CW-1:0] low_cnt_r;
    logic scl_m_r, scl_s_r, alt_m_r, alt_s_r, alt_prev_r;
    logic hw_rst, en, smb, tmo_hit, fault_hit, alert_fall;
    logic setup, wr_en, mapped;
    logic sel_main, sel_dma, sel_addr, sel_stat, sel_pec;
    sbc_reg_t stat_word, pec_word, rd_word, err_set, ev_word;
    sbc_reg_t wr16;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready & pwrite;
    assign wr16 = pwdata[15:0];
    assign sel_main = (paddr == `SBC_OFF_CTL_MAIN);
    assign sel_dma = (paddr == `SBC_OFF_CTL_DMA);
    assign sel_addr = (paddr == `SBC_OFF_OWN_ADDR);
    assign sel_stat = (paddr == `SBC_OFF_STATUS);
    assign sel_pec = (paddr == `SBC_OFF_PEC);
    assign mapped = sel_main | sel_dma | sel_addr | sel_stat | sel_pec;

    // status word: sticky errors over live event levels
    assign ev_word = {8'h00, tx_empty_flag, rx_full_flag, 1'b0, stop_seen_flag,
                      header_sent_flag, byte_done_flag, address_flag, start_sent_flag};
    assign stat_word = (err_r | ev_word) & `SBC_MASK_STATUS;
    assign pec_word = {6'h00, default_addr_seen, host_header_seen, crc_r};
    assign rd_word = sel_main ? ctl_main_r :
                     sel_dma ? ctl_dma_r :
                     sel_addr ? own_addr_r :
                     sel_stat ? stat_word :
                     sel_pec ? pec_word : 16'h0000;

    // read data and answer latched in the setup cycle, zero wait states
    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            if (setup) begin
                prdata <= {16'h0000, rd_word};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            alt_m_r <= 1'b1;
            alt_s_r <= 1'b1;
            alt_prev_r <= 1'b1;
        end else begin
            scl_m_r <= scl_in;
            scl_s_r <= scl_m_r;
            alt_m_r <= alert_pin_in;
            alt_s_r <= alt_m_r;
            alt_prev_r <= alt_s_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // soft reset hold and enables
    assign hw_rst = rst | ctl_main_r[`SBC_B_SOFT_RESET_HOLD];
    assign en = ctl_main_r[`SBC_B_EN];
    assign smb = ctl_main_r[`SBC_B_SMB];
    assign tmo_hit = (low_cnt_r == TMO_C - CW'(1)) & ~scl_s_r;
    assign fault_hit = (low_cnt_r == FAULT_C - CW'(1)) & ~scl_s_r;
    assign alert_fall = alt_prev_r & ~alt_s_r;

    // scl low-time counter, smbus mode only, restarts whenever scl is high
    always_ff @(posedge clk) begin
        if (hw_rst) begin
            low_cnt_r <= '0;
            scl_stuck_fault <= 1'b0;
        end else begin
            if (scl_s_r | ~en | ~smb) begin
                low_cnt_r <= '0;
            end else if (low_cnt_r != FAULT_C) begin
                low_cnt_r <= low_cnt_r + CW'(1);
            end
            if (scl_s_r | ~en | ~smb) begin
                scl_stuck_fault <= 1'b0;
            end else if (fault_hit) begin
                scl_stuck_fault <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control_main: software write, then hardware set and clear
    always_comb begin
        ctl_main_nxt = ctl_main_r;
        if (wr_en & sel_main) begin
            ctl_main_nxt = wr16 & `SBC_MASK_CTL_MAIN;
        end
        if (~ctl_main_nxt[`SBC_B_EN]) begin
            ctl_main_nxt[`SBC_B_POS] = 1'b0;
            ctl_main_nxt[`SBC_B_ACK] = 1'b0;
            ctl_main_nxt[`SBC_B_START] = 1'b0;
            ctl_main_nxt[`SBC_B_PECREQ] = 1'b0;
            ctl_main_nxt[`SBC_B_ALERT] = 1'b0;
        end
        if (start_seen) begin
            ctl_main_nxt[`SBC_B_START] = 1'b0;
        end
        if (pec_done | start_seen | stop_seen) begin
            ctl_main_nxt[`SBC_B_PECREQ] = 1'b0;
        end
        if (stop_seen) begin
            ctl_main_nxt[`SBC_B_STOP] = 1'b0;
        end
        if (tmo_hit) begin
            ctl_main_nxt[`SBC_B_STOP] = 1'b1;
        end
    end

    // control_main keeps its own reset bit so software can release the hold
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_main_r <= `SBC_RST_CTL_MAIN;
        end else begin
            ctl_main_r <= ctl_main_nxt;
        end
    end

    // second control and own address registers
    always_ff @(posedge clk) begin
        if (hw_rst) begin
            ctl_dma_r <= `SBC_RST_CTL_DMA;
            own_addr_r <= `SBC_RST_OWN_ADDR;
        end else begin
            if (wr_en & sel_dma) begin
                ctl_dma_r <= wr16 & `SBC_MASK_CTL_DMA;
            end
            if (wr_en & sel_addr) begin
                own_addr_r <= wr16 & `SBC_MASK_OWN_ADDR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky error flags: write zero clears, a new event in that cycle wins
    assign err_set = {alert_fall & smb & ctl_main_r[`SBC_B_HOST],
                      tmo_hit, 1'b0, crc_mismatch_evt, overrun_evt,
                      ack_error_evt, arb_lost_evt, bus_error_evt, 8'h00};

    always_comb begin
        err_nxt = err_r;
        if (wr_en & sel_stat) begin
            err_nxt = err_r & wr16;
        end
        err_nxt = (err_nxt | err_set) & `SBC_MASK_ERR;
    end

    always_ff @(posedge clk) begin
        if (hw_rst) begin
            err_r <= 16'h0000;
        end else begin
            err_r <= err_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pec crc-8 over every byte on the wire, restarted at start and stop
    always_ff @(posedge clk) begin
        if (hw_rst) begin
            crc_r <= `SBC_CRC_INIT;
        end else if (~en | start_seen | stop_seen) begin
            crc_r <= `SBC_CRC_INIT;
        end else if ((byte_valid | addr_valid) & ctl_main_r[`SBC_B_PECON]) begin
            crc_r <= sbc_crc8(crc_r, byte_data, `SBC_CRC_POLY);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address compare: own 7-bit address or general call when enabled
    logic own_hit, gc_hit;
    assign own_hit = ~own_addr_r[`SBC_B_TENBIT] & (byte_data[7:1] == own_addr_r[7:1]);
    assign gc_hit = (byte_data[7:1] == 7'h00) & ctl_main_r[`SBC_B_GCALL];

    always_ff @(posedge clk) begin
        if (hw_rst) begin
            addr_match <= 1'b0;
            general_call_hit <= 1'b0;
        end else begin
            addr_match <= addr_valid & en & (own_hit | gc_hit);
            general_call_hit <= addr_valid & en & gc_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt gating
    logic ev_any, buf_any;
    assign ev_any = start_sent_flag | address_flag | header_sent_flag |
                    stop_seen_flag | byte_done_flag;
    assign buf_any = ctl_dma_r[`SBC_B_BUFFER_IRQ_ON] & (tx_empty_flag | rx_full_flag);

    always_ff @(posedge clk) begin
        if (hw_rst) begin
            event_irq <= 1'b0;
            error_irq <= 1'b0;
        end else begin
            event_irq <= ctl_dma_r[`SBC_B_EVENT_IRQ_ON] & (ev_any | buf_any);
            error_irq <= ctl_dma_r[`SBC_B_ERROR_IRQ_ON] & (|err_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered controls to the byte engine and the alert pin
    always_ff @(posedge clk) begin
        if (rst) begin
            engine_reset <= 1'b1;
            controller_on <= 1'b0;
            smbus_mode_select <= 1'b0;
            smbus_host_type <= 1'b0;
            addr_resolution_on <= 1'b0;
            pec_calc_on <= 1'b0;
            general_call_respond <= 1'b0;
            stretch_off <= 1'b0;
            gen_start <= 1'b0;
            gen_stop <= 1'b0;
            acknowledge_on <= 1'b0;
            ack_position_next <= 1'b0;
            pec_byte_request <= 1'b0;
            dma_request_on <= 1'b0;
            dma_final_transfer <= 1'b0;
            periph_clock_mhz <= 6'h00;
            scl_half_cycles <= 16'h0000;
            pec_value <= 8'h00;
            alert_pin_out <= 1'b0;
            alert_pin_oe_n <= 1'b1;
        end else begin
            engine_reset <= ctl_main_nxt[`SBC_B_SOFT_RESET_HOLD];
            controller_on <= ctl_main_nxt[`SBC_B_EN];
            smbus_mode_select <= ctl_main_nxt[`SBC_B_SMB];
            smbus_host_type <= ctl_main_nxt[`SBC_B_HOST];
            addr_resolution_on <= ctl_main_nxt[`SBC_B_ARP];
            pec_calc_on <= ctl_main_nxt[`SBC_B_PECON];
            general_call_respond <= ctl_main_nxt[`SBC_B_GCALL];
            stretch_off <= ctl_main_nxt[`SBC_B_NOSTRETCH];
            gen_start <= ctl_main_nxt[`SBC_B_START];
            gen_stop <= ctl_main_nxt[`SBC_B_STOP];
            acknowledge_on <= ctl_main_nxt[`SBC_B_ACK];
            ack_position_next <= ctl_main_nxt[`SBC_B_POS];
            pec_byte_request <= ctl_main_nxt[`SBC_B_PECREQ];
            dma_request_on <= ctl_dma_r[`SBC_B_DMA_REQUEST_ON];
            dma_final_transfer <= ctl_dma_r[`SBC_B_DMALAST];
            periph_clock_mhz <= ctl_dma_r[5:0];
            if (smb & (scl_half_req > HALF_MAX)) begin
                scl_half_cycles <= HALF_MAX;
            end else begin
                scl_half_cycles <= scl_half_req;
            end
            pec_value <= crc_r;
            alert_pin_out <= 1'b0;
            alert_pin_oe_n <= ~ctl_main_nxt[`SBC_B_ALERT];
        end
    end
endmodule

/* File: dv/sbc_ctrl_monitor.sv */
// concurrent checks on the smbus controller ports
`timescale 1ns/1ps

module sbc_ctrl_monitor #(
    parameter int TMO_CYC = 40,
    parameter int FAULT_CYC = 56
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start_seen,
    input wire logic stop_seen,
    input wire logic pec_done,
    input wire logic addr_valid,
    input wire logic [7:0] byte_data,
    input wire logic scl_in,
    input wire logic controller_on,
    input wire logic smbus_mode_select,
    input wire logic general_call_respond,
    input wire logic gen_start,
    input wire logic gen_stop,
    input wire logic acknowledge_on,
    input wire logic ack_position_next,
    input wire logic pec_byte_request,
    input wire logic general_call_hit,
    input wire logic scl_stuck_fault,
    input wire logic alert_pin_out,
    input wire logic alert_pin_oe_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////
    // raw cycles of serial clock low while the timeout may run
    int low_cnt;
    always_ff @(posedge clk) begin
        if (rst || scl_in || !controller_on || !smbus_mode_select) begin
            low_cnt <= 0;
        end else begin
            low_cnt <= low_cnt + 1;
        end
    end

    // general call address seen while answering it is allowed
    sequence s_gc_req;
        controller_on && general_call_respond && addr_valid && byte_data == 8'h00;
    endsequence

    ////////////////////////////////////////////////////////////
    a_start_clear: assert property (start_seen |=> !gen_start)
        else $error("start request survived a start condition");
    a_stop_clear: assert property (stop_seen |=> !gen_stop)
        else $error("stop request survived a stop condition");
    a_pec_clear: assert property ((pec_done || start_seen || stop_seen) |=>
        !pec_byte_request)
        else $error("pec request not cleared");
    a_off_clears: assert property (!controller_on |->
        !(acknowledge_on || ack_position_next || pec_byte_request || gen_start))
        else $error("disabled controller kept a cleared control bit");
    a_gc_hit: assert property (s_gc_req |=> general_call_hit)
        else $error("general call not answered");
    a_gc_cause: assert property (general_call_hit |-> $past(addr_valid) && $past(general_call_respond))
        else $error("general call hit without request");
    a_tmo_stop: assert property (low_cnt == TMO_CYC + 8 |-> gen_stop)
        else $error("timeout did not request a stop");
    a_fault_due: assert property (low_cnt == FAULT_CYC + 8 |-> scl_stuck_fault)
        else $error("stuck clock fault missing");
    a_fault_late: assert property ($rose(scl_stuck_fault) |-> low_cnt >= FAULT_CYC)
        else $error("stuck clock fault too early");
    a_alert_open: assert property (!alert_pin_oe_n |-> controller_on && !alert_pin_out)
        else $error("alert pin driven high or while disabled");
endmodule

bind sbc_ctrl sbc_ctrl_monitor #(.TMO_CYC(TMO_CYC), .FAULT_CYC(FAULT_CYC)) u_mon (
    .clk, .rst, .start_seen, .stop_seen, .pec_done, .addr_valid, .byte_data, .scl_in,
    .controller_on, .smbus_mode_select, .general_call_respond, .gen_start, .gen_stop,
    .acknowledge_on, .ack_position_next, .pec_byte_request, .general_call_hit,
    .scl_stuck_fault, .alert_pin_out, .alert_pin_oe_n
);

/* File: dv/sbc_bus_model.sv */
// far side of the two-wire bus: serial clock source and shared alert wire
`timescale 1ns/1ps

module sbc_bus_model (
    input wire logic in_frame,
    input wire logic hold_low,
    input wire logic alert_req,
    input wire logic alert_pin_out,
    input wire logic alert_pin_oe_n,
    output logic scl,
    output logic alert_line
);
    logic gen = 1'b1;
    // 200 ns clock inside frames only, pulled high between them
    always begin
        #100;
        gen = in_frame ? ~gen : 1'b1;
    end
    // clock held low only when a scenario commands it
    assign scl = hold_low ? 1'b0 : gen;
    // open-drain alert wire with pull-up, low if any party pulls
    assign alert_line = ((!alert_pin_oe_n && !alert_pin_out) || alert_req) ? 1'b0 : 1'b1;
endmodule

/* File: dv/sbc_ctrl_tb.sv */
// self-checking bench for the smbus controller
`timescale 1ns/1ps
`include "sbc_regs.svh"
`define CHK(a, e) begin \
    cmp_count++; \
    if ((a) !== (e)) begin \
        miscompares++; \
        $display("wrong value at %0t: got %h want %h", $time, (a), (e)); \
    end \
end

module sbc_ctrl_tb;
    localparam int TMO = 40;
    localparam int FLT = 56;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [4:0] ev = 5'h00;
    logic [4:0] er = 5'h00;
    logic [6:0] fl = 7'h00;
    logic [7:0] bd = 8'h00;
    logic in_frame = 1'b0;
    logic hold_low = 1'b0;
    logic alert_req = 1'b0;
    logic [15:0] hreq = 16'h0100;
    logic [1:0] hs = 2'h0;
    logic [31:0] q;
    logic perr;
    int miscompares = 0;
    int cmp_count = 0;
    wire [31:0] prdata;
    wire [11:0] ctl_o;
    wire [5:0] pclk;
    wire [7:0] pec;
    wire pready, pslverr, alert_pin_out, alert_pin_oe_n, scl, alert_line;
    wire [15:0] half;
    wire eng_rst, gc_hit, am, stuck, ev_irq, er_irq, dma_on, dma_last;

    ////////////////////////////////////////////////////////////
    sbc_ctrl #(.TMO_CYC(TMO), .FAULT_CYC(FLT)) u_dut (
        .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .scl_in(scl), .alert_pin_in(alert_line), .alert_pin_out, .alert_pin_oe_n,
        .start_seen(ev[4]), .stop_seen(ev[3]), .pec_done(ev[2]), .byte_valid(ev[1]),
        .byte_data(bd), .addr_valid(ev[0]), .bus_error_evt(er[0]), .arb_lost_evt(er[1]),
        .ack_error_evt(er[2]), .overrun_evt(er[3]), .crc_mismatch_evt(er[4]),
        .start_sent_flag(fl[0]), .address_flag(fl[1]), .header_sent_flag(fl[2]),
        .stop_seen_flag(fl[3]), .byte_done_flag(fl[4]), .tx_empty_flag(fl[5]),
        .rx_full_flag(fl[6]), .host_header_seen(hs[0]), .default_addr_seen(hs[1]),
        .scl_half_req(hreq), .engine_reset(eng_rst), .controller_on(ctl_o[0]),
        .smbus_mode_select(ctl_o[1]), .smbus_host_type(ctl_o[2]),
        .addr_resolution_on(ctl_o[3]), .pec_calc_on(ctl_o[4]),
        .general_call_respond(ctl_o[5]), .stretch_off(ctl_o[6]), .gen_start(ctl_o[7]),
        .gen_stop(ctl_o[8]), .acknowledge_on(ctl_o[9]), .ack_position_next(ctl_o[10]),
        .pec_byte_request(ctl_o[11]), .dma_request_on(dma_on), .dma_final_transfer(dma_last),
        .periph_clock_mhz(pclk), .scl_half_cycles(half), .pec_value(pec), .addr_match(am),
        .general_call_hit(gc_hit), .scl_stuck_fault(stuck), .event_irq(ev_irq),
        .error_irq(er_irq)
    );
    sbc_bus_model u_bus (
        .in_frame, .hold_low, .alert_req, .alert_pin_out, .alert_pin_oe_n, .scl, .alert_line
    );

    // 40 MHz clock
    always #12.5 clk = ~clk;

    ////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one apb transfer, held until pready, then an idle cycle
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // one-cycle engine event and error pulses
    task automatic pulse(input logic [4:0] e, input logic [4:0] x, input logic [7:0] b);
        ev <= e;
        er <= x;
        bd <= b;
        @(posedge clk);
        ev <= 5'h00;
        er <= 5'h00;
        @(posedge clk);
    endtask

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////
    task automatic t_regs;
        apb(1'b0, `SBC_OFF_CTL_MAIN, 32'h0);
        `CHK(q, 32'h0)
        apb(1'b1, `SBC_OFF_CTL_DMA, 32'hffff_ffe8);
        apb(1'b0, `SBC_OFF_CTL_DMA, 32'h0);
        `CHK(q, 32'h0000_1f28)
        `CHK({dma_on, dma_last, pclk}, 8'he8)
        apb(1'b1, 8'h30, 32'hffff);
        `CHK(perr, 1'b1)
        apb(1'b0, 8'h30, 32'h0);
        `CHK(q, 32'h0)
    endtask

    task automatic t_soft;
        apb(1'b1, `SBC_OFF_CTL_MAIN, 32'h8000);
        `CHK(eng_rst, 1'b1)
        apb(1'b0, `SBC_OFF_CTL_DMA, 32'h0);
        `CHK(q, 32'h0)
        apb(1'b1, `SBC_OFF_CTL_MAIN, 32'h0);
        `CHK(eng_rst, 1'b0)
    endtask

    task automatic t_ctrl;
        apb(1'b1, `SBC_OFF_CTL_MAIN, 32'h3ffb);
        apb(1'b0, `SBC_OFF_CTL_MAIN, 32'h0);
        `CHK(q, 32'h3ffb)
        `CHK(ctl_o, 12'hfff)
        `CHK({alert_pin_oe_n, alert_pin_out, alert_line}, 3'b000)
        pulse(5'h10, 5'h00, 8'h00);
        cyc(1);
        `CHK({ctl_o[11], ctl_o[7], ctl_o[8]}, 3'b001)
        pulse(5'h08, 5'h00, 8'h00);
        cyc(1);
        `CHK(ctl_o[8], 1'b0)
        apb(1'b1, `SBC_OFF_CTL_MAIN, 32'h3ffb);
        pulse(5'h04, 5'h00, 8'h00);
        cyc(1);
        `CHK({ctl_o[11], ctl_o[7]}, 2'b01)
        apb(1'b1, `SBC_OFF_CTL_MAIN, 32'h3ffa);
        apb(1'b0, `SBC_OFF_CTL_MAIN, 32'h0);
        `CHK(q, 32'h02fa)
        `CHK({alert_pin_oe_n, ctl_o}, 13'h117e)
    endtask

    task automatic t_gcall;
        apb(1'b1, `SBC_OFF_CTL_MAIN, 32'h0041);
        pulse(5'h01, 5'h00, 8'h00);
        `CHK({gc_hit, am}, 2'b11)
        apb(1'b1, `SBC_OFF_CTL_MAIN, 32'h0001);
        pulse(5'h01, 5'h00, 8'h00);
        `CHK({gc_hit, am}, 2'b01)
    endtask

    task automatic t_pec;
        logic [7:0] x;
        x = crc8(crc8(crc8(8'h00, 8'ha6), 8'h01), 8'h5c);
        apb(1'b1, `SBC_OFF_CTL_MAIN, 32'h0021);
        pulse(5'h10, 5'h00, 8'h00);
        pulse(5'h01, 5'h00, 8'ha6);
        pulse(5'h02, 5'h00, 8'h01);
        pulse(5'h02, 5'h00, 8'h5c);
        cyc(1);
        `CHK(pec, x)
        hs <= 2'h3;
        apb(1'b0, `SBC_OFF_PEC, 32'h0);
        `CHK(q[7:0], x)
        `CHK(q[9:8], 2'b11)
    endtask

    task automatic t_irq;
        apb(1'b1, `SBC_OFF_CTL_MAIN, 32'h0001);
        apb(1'b1, `SBC_OFF_STATUS, 32'h0);
        apb(1'b1, `SBC_OFF_CTL_DMA, 32'h0328);
        for (int i = 0; i < 7; i++) begin
            fl <= 7'h01 << i;
            cyc(3);
            `CHK(ev_irq, (i < 5))
        end
        fl <= 7'h60;
        apb(1'b1, `SBC_OFF_CTL_DMA, 32'h0728);
        cyc(1);
        `CHK(ev_irq, 1'b1)
        apb(1'b1, `SBC_OFF_CTL_DMA, 32'h0528);
        cyc(1);
        `CHK(ev_irq, 1'b0)
        fl <= 7'h00;
        for (int i = 0; i < 5; i++) begin
            pulse(5'h00, 5'h01 << i, 8'h00);
            cyc(2);
            `CHK(er_irq, 1'b1)
            apb(1'b0, `SBC_OFF_STATUS, 32'h0);
            `CHK(q[15:8], 8'h01 << i)
            apb(1'b1, `SBC_OFF_STATUS, 32'h0);
            cyc(1);
            `CHK(er_irq, 1'b0)
        end
        apb(1'b1, `SBC_OFF_CTL_DMA, 32'h0028);
        pulse(5'h00, 5'h01, 8'h00);
        cyc(2);
        `CHK(er_irq, 1'b0)
    endtask

    task automatic t_tmo;
        hreq <= 16'h1000;
        cyc(2);
        `CHK(half, 16'h1000)
        apb(1'b1, `SBC_OFF_CTL_MAIN, 32'h000b);
        apb(1'b1, `SBC_OFF_CTL_DMA, 32'h0128);
        `CHK(half, 16'h07d0)
        apb(1'b1, `SBC_OFF_STATUS, 32'h0);
        in_frame <= 1'b1;
        cyc(3 * TMO);
        in_frame <= 1'b0;
        `CHK(er_irq, 1'b0)
        hold_low <= 1'b1;
        cyc(TMO - 10);
        `CHK({er_irq, ctl_o[8]}, 2'b00)
        cyc(20);
        `CHK({er_irq, ctl_o[8], stuck}, 3'b110)
        cyc(FLT - TMO + 10);
        `CHK(stuck, 1'b1)
        hold_low <= 1'b0;
        cyc(5);
        `CHK(stuck, 1'b0)
        alert_req <= 1'b1;
        cyc(4);
        alert_req <= 1'b0;
        apb(1'b0, `SBC_OFF_STATUS, 32'h0);
        `CHK(q[15:14], 2'b11)
    endtask

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_soft;
        t_ctrl;
        t_gcall;
        t_pec;
        t_irq;
        t_tmo;
        end_of_test;
    end

    // watchdog against a hung handshake
    initial begin
        #(25 * 5000);
        miscompares++;
        end_of_test;
    end
endmodule
